/* hw/risa_pkg.sv */
package risa_pkg;

  // ----------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR    = 7'h51;
  localparam logic [7:0] RD_BYTE     = 8'ha3;
  localparam logic [7:0] WR_BYTE     = 8'ha2;
  localparam int         RW_BIT      = 0;

  // ----------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------
  localparam int         REG_AW      = 4;
  localparam int         REG_DEPTH   = 16;
  localparam logic [3:0] PTR_RST     = 4'h0;
  localparam logic [3:0] PTR_LAST    = 4'hf;

  // ----------------------------------------------------------------
  // bit counting
  // ----------------------------------------------------------------
  localparam logic [3:0] RX_LAST     = 4'h8;
  localparam logic [3:0] TX_LAST     = 4'h7;
  localparam logic [3:0] HBIT_LAST   = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TIMEOUT_SEC     = 1;
  localparam int unsigned TIMEOUT_CYCLES  = TIMEOUT_SEC * CLK_HZ;
  localparam int unsigned HOST_QTR_CYCLES = 63;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
    S_WDATA, S_WDATA_ACK, S_TX, S_TX_MACK, S_SKIP
  } risa_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE, H_START, H_BITS, H_STOP
  } risa_host_state_t;

  typedef enum logic [2:0] {
    OP_START_WR, OP_START_RD, OP_WRITE, OP_READ, OP_STOP
  } risa_op_t;

  // ----------------------------------------------------------------
  // pointer step
  // ----------------------------------------------------------------
  // wrap to zero
  function automatic logic [3:0] risa_next_ptr(input logic [3:0] p);
    return (p == PTR_LAST) ? PTR_RST : p + 4'h1;
  endfunction : risa_next_ptr

endpackage : risa_pkg

/* hw/risa_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface risa_if;
  logic scl;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic sda;

  // open-drain wired and with pull-up
  assign sda = (dev_sda_oe_n ? 1'b1 : dev_sda_o) & (host_sda_oe_n ? 1'b1 : host_sda_o);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host   (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface : risa_if

`default_nettype wire

/* hw/risa_device.sv */
// Operation
// - join only when address matches
// - fixed seven bit address 1010001
// - bit zero selects read or write
// - master opens with start plus address
// - write: address, pointer, data, all acked
// - pointer advances after every data byte
// - pointer wraps from f to zero
// - addressed read uses repeated start
// - read returns previously written pointer first
// - master ack requests next byte
// - master nack then stop ends read
// - bare read continues from last plus one
// - one second transaction forces idle
`timescale 1ns/1ps
`default_nettype none

module risa_device
  import risa_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYCLES
) (
  input  wire logic          sys_clk_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  risa_if.device             link,
  input  wire logic          user_we_in,
  input  wire logic [3:0]    user_addr_in,
  input  wire logic [7:0]    user_data_in,
  output logic               wr_stb_out,
  output logic [3:0]         wr_addr_out,
  output logic [7:0]         wr_data_out,
  output logic [3:0]         ptr_out,
  output logic               busy_out,
  output logic               timeout_out
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0]      regs [REG_DEPTH];
  risa_dev_state_t state;
  logic [3:0]      ptr;
  logic [3:0]      cnt;
  logic [7:0]      rx;
  logic [7:0]      tx;
  logic            rw;
  logic            mack;
  logic [31:0]     tmo_cnt;
  logic            tmo_hit;

  logic            scl_s1;
  logic            scl_s2;
  logic            scl_s3;
  logic            sda_s1;
  logic            sda_s2;
  logic            sda_s3;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_det;
  logic            stop_det;
  logic            drive_low;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else if (ce_in) begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise  = scl_s2 & ~scl_s3;
  assign scl_fall  = ~scl_s2 & scl_s3;
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ----------------------------------------------------------------
  // bus timeout
  // ----------------------------------------------------------------
  // start to stop limit
  assign tmo_hit = (state != S_IDLE) && (tmo_cnt == TIMEOUT - 1);

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmo_cnt     <= 32'h0;
      timeout_out <= 1'b0;
    end else if (ce_in) begin
      timeout_out <= tmo_hit;
      if (start_det || state == S_IDLE || tmo_hit) begin
        tmo_cnt <= 32'h0;
      end else begin
        tmo_cnt <= tmo_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state       <= S_IDLE;
      ptr         <= PTR_RST;
      cnt         <= 4'h0;
      rx          <= 8'h00;
      tx          <= 8'hff;
      rw          <= 1'b0;
      mack        <= 1'b1;
      wr_stb_out  <= 1'b0;
      wr_addr_out <= 4'h0;
      wr_data_out <= 8'h00;
    end else if (ce_in) begin
      wr_stb_out <= 1'b0;
      if (tmo_hit) begin
        state <= S_IDLE;
      end else if (start_det) begin
        state <= S_ADDR;
        cnt   <= 4'h0;
      end else if (stop_det) begin
        state <= S_IDLE;
      end else if (scl_rise) begin
        case (state)
          S_ADDR, S_PTR, S_WDATA: begin
            rx  <= {rx[6:0], sda_s2};
            cnt <= cnt + 4'h1;
          end
          S_TX_MACK: begin
            mack <= sda_s2;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            if (cnt == RX_LAST) begin
              if (rx[7:1] == DEV_ADDR) begin
                state <= S_ADDR_ACK;
                rw    <= rx[RW_BIT];
              end else begin
                state <= S_SKIP;
              end
            end
          end
          S_ADDR_ACK: begin
            cnt <= 4'h0;
            if (rw) begin
              state <= S_TX;
              tx    <= regs[ptr];
            end else begin
              state <= S_PTR;
            end
          end
          S_PTR: begin
            if (cnt == RX_LAST) begin
              ptr   <= rx[REG_AW-1:0];
              state <= S_PTR_ACK;
            end
          end
          S_WDATA: begin
            if (cnt == RX_LAST) begin
              wr_stb_out  <= 1'b1;
              wr_addr_out <= ptr;
              wr_data_out <= rx;
              ptr         <= risa_next_ptr(ptr);
              state       <= S_WDATA_ACK;
            end
          end
          S_PTR_ACK, S_WDATA_ACK: begin
            state <= S_WDATA;
            cnt   <= 4'h0;
          end
          S_TX: begin
            if (cnt == TX_LAST) begin
              ptr   <= risa_next_ptr(ptr);
              tx    <= 8'hff;
              state <= S_TX_MACK;
            end else begin
              tx  <= {tx[6:0], 1'b1};
              cnt <= cnt + 4'h1;
            end
          end
          S_TX_MACK: begin
            if (!mack) begin
              state <= S_TX;
              tx    <= regs[ptr];
              cnt   <= 4'h0;
            end else begin
              state <= S_SKIP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (ce_in) begin
      if (wr_stb_out) begin
        regs[wr_addr_out] <= wr_data_out;
      end else if (user_we_in) begin
        regs[user_addr_in] <= user_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  // low only when addressed
  assign drive_low = (state == S_ADDR_ACK) || (state == S_PTR_ACK) ||
                     (state == S_WDATA_ACK) || ((state == S_TX) && !tx[7]);

  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = ~drive_low;
  assign ptr_out           = ptr;
  assign busy_out          = (state != S_IDLE);

endmodule : risa_device

`default_nettype wire

/* hw/risa_host.sv */
`timescale 1ns/1ps
`default_nettype none

module risa_host
  import risa_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = HOST_QTR_CYCLES
) (
  input  wire logic          sys_clk_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  risa_if.host               link,
  input  wire logic          cmd_valid_in,
  input  wire risa_op_t      cmd_op_in,
  input  wire logic [7:0]    cmd_data_in,
  input  wire logic          cmd_ack_in,
  output logic               cmd_ready_out,
  output logic               done_out,
  output logic [7:0]         rdata_out,
  output logic               nack_out,
  output logic               busy_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  risa_host_state_t state;
  logic [1:0]       q;
  logic [31:0]      qcnt;
  logic             tick;
  logic [3:0]       bitn;
  logic [8:0]       tx;
  logic [8:0]       rx;
  logic             sda_s1;
  logic             sda_s2;
  logic             scl_hi;
  logic             sda_low;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else if (ce_in) begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  assign tick = (qcnt == QTR_CYCLES - 1);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state     <= H_IDLE;
      q         <= 2'h0;
      qcnt      <= 32'h0;
      bitn      <= 4'h0;
      tx        <= 9'h1ff;
      rx        <= 9'h1ff;
      busy_out  <= 1'b0;
      done_out  <= 1'b0;
      rdata_out <= 8'h00;
      nack_out  <= 1'b1;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (state == H_IDLE) begin
        q    <= 2'h0;
        qcnt <= 32'h0;
        bitn <= 4'h0;
        if (cmd_valid_in) begin
          case (cmd_op_in)
            // start or repeated start with address
            OP_START_WR: begin
              tx    <= {WR_BYTE, 1'b1};
              state <= H_START;
            end
            OP_START_RD: begin
              tx    <= {RD_BYTE, 1'b1};
              state <= H_START;
            end
            OP_WRITE: begin
              tx    <= {cmd_data_in, 1'b1};
              state <= H_BITS;
            end
            OP_READ: begin
              tx    <= {8'hff, ~cmd_ack_in};
              state <= H_BITS;
            end
            OP_STOP: begin
              state <= H_STOP;
            end
            default: begin
            end
          endcase
        end
      end else if (tick) begin
        qcnt <= 32'h0;
        q    <= q + 2'h1;
        if (state == H_BITS && q == 2'h2) begin
          rx <= {rx[7:0], sda_s2};
        end
        if (q == 2'h3) begin
          case (state)
            H_START: begin
              busy_out <= 1'b1;
              state    <= H_BITS;
            end
            H_BITS: begin
              if (bitn == HBIT_LAST) begin
                rdata_out <= rx[8:1];
                nack_out  <= rx[0];
                done_out  <= 1'b1;
                state     <= H_IDLE;
              end else begin
                bitn <= bitn + 4'h1;
                tx   <= {tx[7:0], 1'b1};
              end
            end
            H_STOP: begin
              busy_out <= 1'b0;
              done_out <= 1'b1;
              state    <= H_IDLE;
            end
            default: begin
              state <= H_IDLE;
            end
          endcase
        end
      end else begin
        qcnt <= qcnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // line levels per quarter
  // ----------------------------------------------------------------
  always_comb begin
    scl_hi  = 1'b1;
    sda_low = 1'b0;
    case (state)
      H_IDLE: begin
        scl_hi = ~busy_out;
      end
      H_START: begin
        scl_hi  = (q == 2'h1) || (q == 2'h2);
        sda_low = (q == 2'h2) || (q == 2'h3);
      end
      H_BITS: begin
        scl_hi  = (q == 2'h1) || (q == 2'h2);
        sda_low = ~tx[8];
      end
      H_STOP: begin
        scl_hi  = (q != 2'h0);
        sda_low = (q == 2'h0) || (q == 2'h1);
      end
      default: begin
      end
    endcase
  end

  assign link.scl           = scl_hi;
  assign link.host_sda_o    = 1'b0;
  assign link.host_sda_oe_n = ~sda_low;
  assign cmd_ready_out      = (state == H_IDLE);

endmodule : risa_host

`default_nettype wire

/* verification/risa_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module risa_asserts
  import risa_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  // ----------------------------------------
  // bus event tracking
  // ----------------------------------------
  logic        s_scl;
  logic        s_sda;
  logic        active;
  logic        first;
  logic        rd;
  logic        nacked;
  logic [3:0]  bitn;
  logic [7:0]  sh;
  int unsigned tcnt;
  wire logic   strt  = s_scl & scl & s_sda & ~sda;
  wire logic   stp   = s_scl & scl & ~s_sda & sda;
  wire logic   slot  = ~s_scl & scl & active & (bitn == 4'h8);
  wire logic   alive = (tcnt + 16) < TIMEOUT;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_scl <= 1'b1;
      s_sda <= 1'b1;
    end else begin
      s_scl <= scl;
      s_sda <= sda;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active <= 1'b0;
      tcnt   <= 0;
    end else if (strt) begin
      active <= 1'b1;
      tcnt   <= 0;
    end else if (stp) begin
      active <= 1'b0;
    end else if (active) begin
      tcnt <= tcnt + 1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bitn   <= 4'h0;
      first  <= 1'b0;
      rd     <= 1'b0;
      nacked <= 1'b0;
      sh     <= 8'h00;
    end else if (strt) begin
      bitn   <= 4'h0;
      first  <= 1'b1;
      nacked <= 1'b0;
    end else if (active && !s_scl && scl) begin
      if (bitn != 4'h8) begin
        sh   <= {sh[6:0], sda};
        bitn <= bitn + 4'h1;
      end else begin
        bitn  <= 4'h0;
        first <= 1'b0;
        if (first) rd <= sh[0];
        if (!first && rd && sda) nacked <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_addr_ack;
    slot && first && sh[7:1] == DEV_ADDR |-> !dev_sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acked");
  property p_write_ack;
    slot && !first && !rd && alive |-> !dev_sda_oe_n ##1 (!dev_sda_oe_n) [*4];
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("written byte not acked and held");
  property p_master_slot;
    slot && !first && rd |-> dev_sda_oe_n;
  endproperty
  a_master_slot: assert property (p_master_slot)
    else $error("device drives in master ack slot");
  property p_nack_quiet;
    active && nacked |-> dev_sda_oe_n;
  endproperty
  a_nack_quiet: assert property (p_nack_quiet)
    else $error("device drives after master nack");
  property p_timeout;
    active && tcnt > TIMEOUT + 8 |-> dev_sda_oe_n;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("device drives after bus timeout");
  property p_scl_low;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("device changes data while clock high");
  property p_pull_only;
    !dev_sda_oe_n |-> !dev_sda_o;
  endproperty
  a_pull_only: assert property (p_pull_only)
    else $error("device drives data line high");
  property p_idle_quiet;
    !active |-> dev_sda_oe_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("device drives outside a transaction");
endmodule : risa_asserts

`default_nettype wire

/* verification/rtc_i2c_slave_access_test.sv */
`timescale 1ns/1ps
`default_nettype none

module rtc_i2c_slave_access_test
  import risa_pkg::*;
;
  localparam int unsigned TOUT = 2000;
  logic       sys_clk_in;
  logic       nrst_in;
  logic       cmd_valid;
  logic       cmd_ack;
  risa_op_t   cmd_op;
  logic [7:0] cmd_data;
  logic       u_we;
  logic [3:0] u_addr;
  logic [7:0] u_data;
  logic       ready;
  logic       done;
  logic       nack;
  logic       tmo;
  logic [7:0] rdata;
  logic [7:0] wr_data;
  logic [3:0] wr_addr;
  logic [3:0] ptr;
  logic [8:0] wire_sh;
  logic       wr_stb;
  logic       dbusy;
  logic       hbusy;
  int         wr_cnt;
  int         err_total;
  int         compares;

  risa_if if_a ();
  risa_if if_b ();

  risa_device #(.TIMEOUT(TOUT)) i_risa_device (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .ce_in        (1'b1),
    .link         (if_a),
    .user_we_in   (u_we),
    .user_addr_in (u_addr),
    .user_data_in (u_data),
    .wr_stb_out   (wr_stb),
    .wr_addr_out  (wr_addr),
    .wr_data_out  (wr_data),
    .ptr_out      (ptr),
    .busy_out     (dbusy),
    .timeout_out  (tmo)
  );
  risa_device #(.TIMEOUT(TOUT)) i_risa_device_b (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .ce_in        (1'b1),
    .link         (if_b),
    .user_we_in   (u_we),
    .user_addr_in (u_addr),
    .user_data_in (u_data),
    .wr_stb_out   (),
    .wr_addr_out  (),
    .wr_data_out  (),
    .ptr_out      (),
    .busy_out     (),
    .timeout_out  ()
  );
  risa_host #(.QTR_CYCLES(6)) i_risa_host (
    .sys_clk_in    (sys_clk_in),
    .nrst_in       (nrst_in),
    .ce_in         (1'b1),
    .link          (if_a),
    .cmd_valid_in  (cmd_valid),
    .cmd_op_in     (cmd_op),
    .cmd_data_in   (cmd_data),
    .cmd_ack_in    (cmd_ack),
    .cmd_ready_out (ready),
    .done_out      (done),
    .rdata_out     (rdata),
    .nack_out      (nack),
    .busy_out      (hbusy)
  );
  risa_asserts #(.TIMEOUT(TOUT)) i_risa_asserts (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .scl          (if_a.scl),
    .sda          (if_a.sda),
    .dev_sda_o    (if_a.dev_sda_o),
    .dev_sda_oe_n (if_a.dev_sda_oe_n)
  );

  // ----------------------------------------
  // clock and wire monitor
  // ----------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge if_a.scl) wire_sh <= {wire_sh[7:0], if_a.sda};

  // counts bus writes landing in the array
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_cnt <= 0;
    end else if (wr_stb === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic cmd(input risa_op_t op, input logic [7:0] d, input logic a);
    int n;
    for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge sys_clk_in);
    if (ready !== 1'b1) begin
      chk("command ready", 9'h001, 9'h000);
      end_sim();
    end
    cmd_op    = op;
    cmd_data  = d;
    cmd_ack   = a;
    cmd_valid = 1'b1;
    @(negedge sys_clk_in);
    cmd_valid = 1'b0;
    for (n = 0; n < 20000 && done !== 1'b1; n++) @(negedge sys_clk_in);
    if (done !== 1'b1) begin
      chk("command done", 9'h001, 9'h000);
      end_sim();
    end
  endtask : cmd

  task automatic qd();
    repeat (2) @(negedge sys_clk_in);
  endtask : qd

  task automatic bb_bit(input logic b, output logic s);
    if_b.scl = 1'b0;
    qd();
    if_b.host_sda_oe_n = b;
    qd();
    if_b.scl = 1'b1;
    qd();
    s = if_b.sda;
    qd();
  endtask : bb_bit

  task automatic bb_byte(input logic [7:0] d, input logic exp_ack, input string nm);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(d[i], s);
    bb_bit(1'b1, s);
    chk(nm, {8'h00, exp_ack}, {8'h00, s});
  endtask : bb_byte

  task automatic bb_edge(input logic b);
    if_b.scl = 1'b0;
    qd();
    if_b.host_sda_oe_n = b;
    qd();
    if_b.scl = 1'b1;
    qd();
    if_b.host_sda_oe_n = ~b;
    qd();
  endtask : bb_edge

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    int n;
    err_total = 0;
    compares = 0;
    nrst_in = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_STOP;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    u_we = 1'b0;
    u_addr = 4'h1;
    u_data = 8'h77;
    if_b.scl = 1'b1;
    if_b.host_sda_o = 1'b0;
    if_b.host_sda_oe_n = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    nrst_in = 1'b1;
    u_we = 1'b1;
    @(negedge sys_clk_in);
    u_we = 1'b0;
    cmd(OP_START_WR, 8'h00, 1'b0);
    chk("address ack", 9'h000, {8'h00, nack});
    chk("write address on wire", {WR_BYTE, 1'b0}, wire_sh);
    cmd(OP_WRITE, 8'h0f, 1'b0);
    chk("pointer ack", 9'h000, {8'h00, nack});
    cmd(OP_WRITE, 8'h5a, 1'b0);
    chk("first write addr", 9'h00f, {5'h00, wr_addr});
    cmd(OP_WRITE, 8'h3c, 1'b0);
    chk("wrapped write addr", 9'h000, {5'h00, wr_addr});
    chk("wrapped write data", 9'h03c, {1'b0, wr_data});
    cmd(OP_STOP, 8'h00, 1'b0);
    chk("pointer after write", 9'h001, {5'h00, ptr});
    chk("bus writes", 9'h002, wr_cnt[8:0]);
    chk("device idle after stop", 9'h000, {8'h00, dbusy});
    chk("host idle after stop", 9'h000, {8'h00, hbusy});
    cmd(OP_START_WR, 8'h00, 1'b0);
    cmd(OP_WRITE, 8'h0f, 1'b0);
    cmd(OP_START_RD, 8'h00, 1'b0);
    chk("read address on wire", {RD_BYTE, 1'b0}, wire_sh);
    cmd(OP_READ, 8'h00, 1'b1);
    chk("first read byte", 9'h05a, {1'b0, rdata});
    cmd(OP_READ, 8'h00, 1'b0);
    chk("wrapped read byte", 9'h03c, {1'b0, rdata});
    chk("master nack on wire", 9'h001, {8'h00, wire_sh[0]});
    cmd(OP_STOP, 8'h00, 1'b0);
    cmd(OP_START_RD, 8'h00, 1'b0);
    cmd(OP_READ, 8'h00, 1'b0);
    chk("bare read byte", 9'h077, {1'b0, rdata});
    cmd(OP_STOP, 8'h00, 1'b0);
    cmd(OP_START_WR, 8'h00, 1'b0);
    for (n = 0; n < TOUT + 500 && tmo !== 1'b1; n++) @(negedge sys_clk_in);
    chk("timeout pulse", 9'h001, {8'h00, tmo});
    if (tmo !== 1'b1) begin
      end_sim();
    end
    chk("device idle after timeout", 9'h000, {8'h00, dbusy});
    cmd(OP_READ, 8'h00, 1'b0);
    chk("read after timeout", 9'h0ff, {1'b0, rdata});
    cmd(OP_WRITE, 8'h11, 1'b0);
    chk("write after timeout", 9'h001, {8'h00, nack});
    cmd(OP_STOP, 8'h00, 1'b0);
    chk("pointer after timeout", 9'h002, {5'h00, ptr});
    chk("writes after timeout", 9'h002, wr_cnt[8:0]);
    bb_edge(1'b1);
    bb_byte(8'hb2, 1'b1, "foreign address ack");
    bb_byte(8'h00, 1'b1, "byte after mismatch");
    bb_edge(1'b1);
    bb_byte(WR_BYTE, 1'b0, "own address ack");
    bb_edge(1'b0);
    end_sim();
  end
endmodule : rtc_i2c_slave_access_test

`default_nettype wire
